// [hdl/coulomb_counter_compare.sv]
// Function
// - Two independent 32-bit tallies count up only, one per unit.
// - Charge units advance charge tally; discharge units advance discharge tally only.
// - Counter select bit chooses the tally for snapshot and equality check.
// - Snapshot holds four bytes, byte0 least through byte3 most significant.
// - Both tallies clear on reset and when the clear bit is written.
// - Tallies wrap to zero past full value with no flag.
// - Command 0x82 enables snapshot updates and returns snapshot bytes 0 and 1.
// - Low-read snapshot loads once the event toggled on the command acknowledge rise reaches the core clock.
// - While updating is enabled, every new command other than 0x83 reloads the snapshot.
// - Command 0x83 disables updating first, then returns bytes 2 and 3.
// - Command 0x84 returns status low byte and all ones high byte.
// - Enabled check compares selected tally with threshold, sets flag, alert low.
// - Equality check enabled by config bit, disabled at reset.
// - Threshold holds its value until rewritten or reset.
// - Threshold holds four bytes, byte0 least through byte3 most significant.
// - Low threshold write closes alert gate on 18th rise, loads bytes 0, 1.
// - High threshold write loads bytes 2, 3, reopens gate after 36th rise.
// - Write code 0x00 is the low threshold write.
// - Write code 0x01 is the high threshold write.
// - Write code 0x04 writes both bytes into the configuration word.
`timescale 1ns/10ps
`default_nettype none
`include "ccc_map.svh"

module coulomb_counter_compare (
  input  wire logic clock_in,       // Core clock, 125 MHz.
  input  wire logic reset_n_in,     // Power-on reset, active low, asynchronous.
  input  wire logic charge_unit_in, // One-cycle charge count strobe.
  input  wire logic dischg_unit_in, // One-cycle discharge count strobe.
  input  wire logic scl_in,         // Serial clock pin.
  input  wire logic sda_in,         // Serial data pin level.
  output logic      sda_out,        // Serial data drive value, always low.
  output logic      sda_oe_out,     // Serial data output enable.
  output logic      host_alert_n_out, // Match alert, active low.
  output logic      match_flag_out  // Match flag level.
);

  // ---------------------------------------------------------------
  // Local state
  // ---------------------------------------------------------------
  logic [31:0] charge_accumulator_r;
  logic [31:0] discharge_accumulator_r;
  logic [31:0] tally_snapshot_r;
  logic [31:0] threshold_word_r;
  logic [15:0] config_word_r;
  logic        snap_update_en_r;
  logic        match_alert_gate_r;
  logic        match_flag_r;
  logic [15:0] rd_word_r;
  logic        evt_tgl_link;
  logic        evt_tgl_sync;
  logic        evt_tgl_q_r;
  logic        evt_new;
  ccc_pkg::ccc_link_evt_s evt_link;
  ccc_pkg::ccc_link_evt_s evt_r;
  logic        sda_oe_link;
  logic        gate_off_sync;
  logic        gate_on_sync;
  logic        gate_off_q_r;
  logic        gate_on_q_r;
  logic        scl_sync;
  logic        sda_sync;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        start_r;
  logic [31:0] selected_tally_value;
  ccc_pkg::ccc_cfg_s cfg;

  // Configuration fields used by the core.
  assign cfg.select = config_word_r[`CCC_CFG_SELECT_BIT];
  assign cfg.clear  = config_word_r[`CCC_CFG_CLEAR_BIT];
  assign cfg.enable = config_word_r[`CCC_CFG_ENABLE_BIT];

  // Two-input selector between the tallies.
  assign selected_tally_value = cfg.select ? discharge_accumulator_r : charge_accumulator_r;

  // ---------------------------------------------------------------
  // Pin synchronisers for start detection
  // ---------------------------------------------------------------
  ccc_sync_bit u_sync_scl (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (scl_in),
    .sync_out   (scl_sync)
  );

  ccc_sync_bit u_sync_sda (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (sda_in),
    .sync_out   (sda_sync)
  );

  // Start sets, SCL low clears; the link samples this as a level.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      start_r <= 1'b0;
    end else begin
      scl_q_r <= scl_sync;
      sda_q_r <= sda_sync;
      if (scl_sync && scl_q_r && sda_q_r && !sda_sync) begin
        start_r <= 1'b1;
      end else if (!scl_sync) begin
        start_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial link engine on the SCL domain
  // ---------------------------------------------------------------
  ccc_link u_link (
    .scl_in      (scl_in),
    .reset_n_in  (reset_n_in),
    .sda_in      (sda_in),
    .start_in    (start_r),
    .addr_in     (7'h0b),
    .rd_word_in  (rd_word_r),
    .sda_oe_out  (sda_oe_link),
    .evt_tgl_out (evt_tgl_link),
    .evt_out     (evt_link)
  );

  ccc_sync_bit u_sync_evt (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (evt_tgl_link),
    .sync_out   (evt_tgl_sync)
  );

  ccc_sync_bit u_sync_goff (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (evt_link.gate_off),
    .sync_out   (gate_off_sync)
  );

  ccc_sync_bit u_sync_gon (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (evt_link.gate_on),
    .sync_out   (gate_on_sync)
  );

  assign evt_new = evt_tgl_sync ^ evt_tgl_q_r;

  // Event record is stable by the time its toggle arrives.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_tgl_q_r  <= 1'b0;
      evt_r        <= '0;
      gate_off_q_r <= 1'b0;
      gate_on_q_r  <= 1'b0;
    end else begin
      evt_tgl_q_r  <= evt_tgl_sync;
      gate_off_q_r <= gate_off_sync;
      gate_on_q_r  <= gate_on_sync;
      if (evt_new) begin
        evt_r <= evt_link;
      end
    end
  end

  // ---------------------------------------------------------------
  // Tallies
  // ---------------------------------------------------------------
  // Up-only counting; natural wrap at full scale raises nothing.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      charge_accumulator_r <= 32'h0000_0000;
    end else if (cfg.clear) begin
      charge_accumulator_r <= 32'h0000_0000;
    end else if (charge_unit_in) begin
      charge_accumulator_r <= charge_accumulator_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      discharge_accumulator_r <= 32'h0000_0000;
    end else if (cfg.clear) begin
      discharge_accumulator_r <= 32'h0000_0000;
    end else if (dischg_unit_in) begin
      discharge_accumulator_r <= discharge_accumulator_r + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Snapshot and command decode
  // ---------------------------------------------------------------
  // A command event arrives through the synchroniser after the command acknowledge rise.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snap_update_en_r <= 1'b0;
      tally_snapshot_r <= 32'h0000_0000;
    end else if (evt_new && evt_link.cmd_seen) begin
      if (evt_link.cmd == `CCC_CMD_RD_SNAP_HIGH) begin
        snap_update_en_r <= 1'b0;
      end else if (evt_link.cmd == `CCC_CMD_RD_SNAP_LOW) begin
        snap_update_en_r <= 1'b1;
        tally_snapshot_r <= selected_tally_value;
      end else if (snap_update_en_r) begin
        tally_snapshot_r <= selected_tally_value;
      end
    end
  end

  // Read word by command, low byte in bits 7:0.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_word_r <= 16'hffff;
    end else begin
      unique case (evt_r.cmd)
        `CCC_CMD_RD_SNAP_LOW:  rd_word_r <= tally_snapshot_r[15:0];
        `CCC_CMD_RD_SNAP_HIGH: rd_word_r <= tally_snapshot_r[31:16];
        `CCC_CMD_RD_STATUS:    rd_word_r <= {`CCC_STATUS_HIGH, 7'h00, match_flag_r};
        default:               rd_word_r <= 16'hffff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Write-Word decode: threshold and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      threshold_word_r <= `CCC_THR_RESET;
      config_word_r    <= `CCC_CFG_RESET;
    end else begin
      if (cfg.clear) begin
        config_word_r[`CCC_CFG_CLEAR_BIT] <= 1'b0;
      end
      if (evt_new && evt_link.wr_done) begin
        unique case (evt_link.cmd)
          `CCC_CMD_WR_THR_LOW:  threshold_word_r[15:0]  <= evt_link.data;
          `CCC_CMD_WR_THR_HIGH: threshold_word_r[31:16] <= evt_link.data;
          `CCC_CMD_WR_CONFIG:   config_word_r           <= evt_link.data;
          default:              config_word_r           <= config_word_r;
        endcase
      end
    end
  end

  // Alert gate follows the SCL-edge markers from the link.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      match_alert_gate_r <= 1'b1;
    end else if (gate_on_sync && !gate_on_q_r) begin
      match_alert_gate_r <= 1'b1;
    end else if (gate_off_sync && !gate_off_q_r) begin
      match_alert_gate_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Equality check and outputs
  // ---------------------------------------------------------------
  // Flag stays set once seen; a low-threshold write clears it unless a match holds in that cycle.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      match_flag_r <= 1'b0;
    end else if (cfg.enable && selected_tally_value == threshold_word_r) begin
      match_flag_r <= 1'b1;
    end else if (evt_new && evt_link.wr_done && evt_link.cmd == `CCC_CMD_WR_THR_LOW) begin
      match_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_alert_n_out <= 1'b1;
      match_flag_out   <= 1'b0;
      sda_out          <= 1'b0;
    end else begin
      host_alert_n_out <= ~(match_flag_r && match_alert_gate_r);
      match_flag_out   <= match_flag_r;
      sda_out          <= 1'b0;
    end
  end

  assign sda_oe_out = sda_oe_link;

endmodule

`default_nettype wire

// [hdl/ccc_map.svh]
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// Command codes.
`define CCC_CMD_WR_THR_LOW   8'h00
`define CCC_CMD_WR_THR_HIGH  8'h01
`define CCC_CMD_WR_CONFIG    8'h04
`define CCC_CMD_RD_SNAP_LOW  8'h82
`define CCC_CMD_RD_SNAP_HIGH 8'h83
`define CCC_CMD_RD_STATUS    8'h84

// Configuration word field positions.
`define CCC_CFG_SELECT_BIT   0
`define CCC_CFG_CLEAR_BIT    1
`define CCC_CFG_ENABLE_BIT   2

// Status word field positions.
`define CCC_STS_MATCH_BIT    0

// Reset values and the status high byte.
`define CCC_CFG_RESET        16'h0000
`define CCC_THR_RESET        32'h0000_0000
`define CCC_STATUS_HIGH      8'hff

// SCL edge positions within a Write-Word transaction.
`define CCC_GATE_OFF_RISE    8'd18
`define CCC_GATE_ON_RISE     8'd36

`endif

// [hdl/ccc_pkg.sv]
package ccc_pkg;

  // Serial-side event carried into the core clock domain.
  typedef struct packed {
    logic        cmd_seen;   // New command byte acknowledged.
    logic        wr_done;    // Write-Word data complete.
    logic        gate_off;   // 18th rising SCL of a low-threshold write.
    logic        gate_on;    // Falling SCL after the 36th rising edge.
    logic [7:0]  cmd;        // Command code.
    logic [15:0] data;       // Write data, low byte in bits 7:0.
  } ccc_link_evt_s;

  // Configuration word fields.
  typedef struct packed {
    logic select;            // Chooses discharge tally when set.
    logic clear;             // Clears both tallies.
    logic enable;            // Enables the equality check.
  } ccc_cfg_s;

  // Serial engine states.
  typedef enum logic [2:0] {
    CCC_IDLE,
    CCC_ADDR,
    CCC_CMD,
    CCC_WDATA,
    CCC_RADDR,
    CCC_RDATA,
    CCC_SKIP
  } ccc_link_state_e;

endpackage

// [hdl/ccc_sync_bit.sv]
`timescale 1ns/10ps
`default_nettype none

module ccc_sync_bit (
  input  wire logic clock_in,    // Destination clock.
  input  wire logic reset_n_in,  // Asynchronous reset, active low.
  input  wire logic async_in,    // Level from another domain.
  output logic      sync_out     // Synchronised level.
);

  logic meta_r;

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  // Only the second stage reads the first one.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// [hdl/ccc_link.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ccc_map.svh"

module ccc_link (
  input  wire logic            scl_in,       // Serial clock, clocks this module.
  input  wire logic            reset_n_in,   // Asynchronous reset, active low.
  input  wire logic            sda_in,       // Serial data level.
  input  wire logic            start_in,     // Start seen, level from core.
  input  wire logic [6:0]      addr_in,      // Own seven-bit address.
  input  wire logic [15:0]     rd_word_in,   // Read word, stable from command.
  output logic                 sda_oe_out,   // Drives SDA low when high.
  output logic                 evt_tgl_out,  // Toggles per new event record.
  output ccc_pkg::ccc_link_evt_s evt_out     // Event record.
);

  ccc_pkg::ccc_link_state_e state_r;
  logic [7:0]             shift_r;
  logic [3:0]             bit_r;
  logic [7:0]             rise_r;
  logic [7:0]             wlow_r;
  logic [15:0]            rdata_r;
  logic                   start_q_r;
  logic                   wbyte_r;
  logic                   gate_on_r;
  logic                   addr_hit;
  ccc_pkg::ccc_link_evt_s evt_q_r;

  // The address byte is complete once eight bits are in.
  assign addr_hit = (shift_r[7:1] == addr_in);

  // Record from the rising-edge process, reopen marker from the falling one.
  always_comb begin
    evt_out         = evt_q_r;
    evt_out.gate_on = gate_on_r;
  end

  // ---------------------------------------------------------------
  // Rising SCL: sample SDA, count bits and edges
  // ---------------------------------------------------------------
  // A start seen by the core restarts the frame at the next rise.
  always_ff @(posedge scl_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r     <= ccc_pkg::CCC_IDLE;
      shift_r     <= 8'h00;
      bit_r       <= 4'h0;
      rise_r      <= 8'h00;
      wlow_r      <= 8'h00;
      wbyte_r     <= 1'b0;
      start_q_r   <= 1'b0;
      evt_tgl_out <= 1'b0;
      evt_q_r     <= '0;
    end else begin
      start_q_r        <= start_in;
      evt_q_r.gate_off <= 1'b0;
      if (start_in && !start_q_r) begin
        state_r <= ccc_pkg::CCC_ADDR;
        shift_r <= {7'h00, sda_in};
        bit_r   <= 4'h1;
        rise_r  <= 8'h01;
      end else if (state_r != ccc_pkg::CCC_IDLE) begin
        rise_r <= rise_r + 8'h01;
        if (bit_r == 4'h8) begin
          // Ninth bit: the acknowledge slot, with the byte complete in shift_r.
          bit_r <= 4'h0;
          unique case (state_r)
            ccc_pkg::CCC_ADDR: begin
              if (!addr_hit) begin
                state_r <= ccc_pkg::CCC_SKIP;
              end else if (shift_r[0]) begin
                state_r <= ccc_pkg::CCC_RDATA;
              end else begin
                state_r <= ccc_pkg::CCC_CMD;
              end
            end
            ccc_pkg::CCC_CMD: begin
              state_r          <= ccc_pkg::CCC_WDATA;
              wbyte_r          <= 1'b0;
              evt_q_r.cmd      <= shift_r;
              evt_q_r.cmd_seen <= 1'b1;
              evt_q_r.wr_done  <= 1'b0;
              evt_tgl_out      <= ~evt_tgl_out;
              // Low-threshold writes close the alert gate on the 18th rise.
              evt_q_r.gate_off <= (rise_r + 8'h01 == `CCC_GATE_OFF_RISE)
                                  && (shift_r == `CCC_CMD_WR_THR_LOW);
            end
            ccc_pkg::CCC_WDATA: begin
              wbyte_r <= 1'b1;
              if (!wbyte_r) begin
                wlow_r <= shift_r;
              end else begin
                evt_q_r.data     <= {shift_r, wlow_r};
                evt_q_r.cmd_seen <= 1'b0;
                evt_q_r.wr_done  <= 1'b1;
                evt_tgl_out      <= ~evt_tgl_out;
                state_r          <= ccc_pkg::CCC_SKIP;
              end
            end
            // The host's acknowledge asks for another byte; a refusal ends the read.
            ccc_pkg::CCC_RDATA: state_r <= sda_in ? ccc_pkg::CCC_SKIP : ccc_pkg::CCC_RDATA;
            default: state_r <= state_r;
          endcase
        end else begin
          bit_r   <= bit_r + 4'h1;
          shift_r <= {shift_r[6:0], sda_in};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Falling SCL: acknowledge, read data and gate reopen
  // ---------------------------------------------------------------
  // SDA changes only while SCL is low.
  always_ff @(negedge scl_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_oe_out <= 1'b0;
      rdata_r    <= 16'h0000;
      gate_on_r  <= 1'b0;
    end else begin
      // Gate reopens on the fall after the 36th rise of a high write.
      gate_on_r <= (rise_r == `CCC_GATE_ON_RISE) && (evt_q_r.cmd == `CCC_CMD_WR_THR_HIGH);
      if (state_r == ccc_pkg::CCC_RDATA) begin
        // Data bits go out most significant first; the line is let go for the host's acknowledge.
        sda_oe_out <= (bit_r != 4'h8) && !rdata_r[15];
        if (bit_r != 4'h8) begin
          rdata_r <= {rdata_r[14:0], 1'b1};
        end
      end else begin
        rdata_r    <= {rd_word_in[7:0], rd_word_in[15:8]};
        // Acknowledge the own address, the command and each written byte.
        sda_oe_out <= (bit_r == 4'h8) && (state_r == ccc_pkg::CCC_CMD || state_r == ccc_pkg::CCC_WDATA
                      || (state_r == ccc_pkg::CCC_ADDR && addr_hit));
      end
    end
  end

endmodule

`default_nettype wire

// [tb/ccc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks.
// ----
module ccc_checker (
  input wire logic clock_in,         // Clock.
  input wire logic reset_n_in,       // Reset.
  input wire logic charge_unit_in,   // Strobe.
  input wire logic dischg_unit_in,   // Strobe.
  input wire logic scl_in,           // Bus clock.
  input wire logic sda_in,           // Data.
  input wire logic sda_out,          // Drive.
  input wire logic sda_oe_out,       // Enable.
  input wire logic host_alert_n_out, // Alert.
  input wire logic match_flag_out    // Flag.
);
  logic       scl_seen_r; // Last bus clock.
  logic [7:0] scl_age_r;  // Cycles since bus clock moved.
  logic [7:0] evt_age_r;  // Cycles since any cause.

  // Ages saturate over long idle spans.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_seen_r <= 1'b1;
      scl_age_r <= 8'hff;
    end else begin
      scl_seen_r <= scl_in;
      if (scl_in != scl_seen_r) begin
        scl_age_r <= 8'h00;
      end else if (scl_age_r != 8'hff) begin
        scl_age_r <= scl_age_r + 8'h01;
      end
    end
  end

  // A strobe or a bus move restarts this age.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_age_r <= 8'hff;
    end else if (charge_unit_in || dischg_unit_in || scl_in != scl_seen_r) begin
      evt_age_r <= 8'h00;
    end else if (evt_age_r != 8'hff) begin
      evt_age_r <= evt_age_r + 8'h01;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  a_reset_outputs_rest: assert property ($rose(reset_n_in) |-> !match_flag_out && host_alert_n_out)
    else $error("outputs not at rest after reset");
  a_alert_needs_flag: assert property (!host_alert_n_out |-> match_flag_out || $past(match_flag_out))
    else $error("alert low without flag");
  a_flag_fall_bus: assert property ($fell(match_flag_out) |-> scl_age_r < 8'h40)
    else $error("flag dropped without bus traffic");
  a_flag_rise_cause: assert property ($rose(match_flag_out) |-> evt_age_r < 8'h30)
    else $error("flag rose without a cause");
  a_alert_rise_bus: assert property ($rose(host_alert_n_out) |-> scl_age_r < 8'h40)
    else $error("alert released without bus traffic");
  a_alert_fall_cause: assert property ($fell(host_alert_n_out) |-> evt_age_r < 8'h30)
    else $error("alert fell without a cause");
  a_sda_drive_low: assert property (sda_oe_out |-> !sda_out)
    else $error("data driven high");
  a_sda_idle_free: assert property (scl_in && scl_age_r > 8'h28 |-> !sda_oe_out)
    else $error("data held while bus idle");
  a_oe_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data enable moved with clock high");

  c_flag_rise: cover property ($rose(match_flag_out));
  c_alert_low: cover property (!host_alert_n_out);
  c_drive: cover property ($rose(sda_oe_out));
endmodule

bind coulomb_counter_compare ccc_checker u_checker (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .charge_unit_in(charge_unit_in),
  .dischg_unit_in(dischg_unit_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .host_alert_n_out(host_alert_n_out), .match_flag_out(match_flag_out)
);
`default_nettype wire

// [tb/ccc_smbus_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ----
// Bus host model.
// ----
module ccc_smbus_host #(
  parameter logic [6:0] DEV_ADDR = 7'h0b // Device address.
) (
  input  wire logic sda_in,    // Resolved data wire.
  output var logic  scl_out,   // Bus clock, high between frames.
  output var logic  sda_oe_out // Pulls data low when high.
);
  int nack_count; // Bytes left unacknowledged.

  // Both lines rest released.
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    nack_count = 0;
  end

  // One 30 ns bit: data moves early in the low phase, is read late in the high.
  task automatic bit_slot(input logic b, output logic r);
    scl_out = 1'b0;
    #5;
    sda_oe_out = !b;
    #10;
    scl_out = 1'b1;
    #8;
    r = sda_in;
    #7;
  endtask

  // Start, or repeated start when a frame is open; long holds let the core see it.
  task automatic start_cond(input logic again);
    if (again) begin
      scl_out = 1'b0;
      #5;
      sda_oe_out = 1'b0;
      #10;
      scl_out = 1'b1;
    end
    #40;
    sda_oe_out = 1'b1;
    #40;
  endtask

  // Stop, then the clock stands high.
  task automatic stop_cond;
    scl_out = 1'b0;
    #5;
    sda_oe_out = 1'b1;
    #10;
    scl_out = 1'b1;
    #40;
    sda_oe_out = 1'b0;
    #80;
  endtask

  // Sends a byte most significant bit first and checks the acknowledge.
  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, r);
    if (r !== 1'b0) nack_count++;
  endtask

  // Reads a byte, then acknowledges unless it is the last.
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      b[i] = r;
    end
    bit_slot(last, r);
  endtask

  // Write-Word, low data byte first.
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] data);
    start_cond(1'b0);
    send_byte({DEV_ADDR, 1'b0});
    send_byte(cmd);
    send_byte(data[7:0]);
    send_byte(data[15:8]);
    stop_cond();
  endtask

  // Read-Word through a repeated start.
  task automatic rd_word(input logic [7:0] cmd, output logic [15:0] data);
    start_cond(1'b0);
    send_byte({DEV_ADDR, 1'b0});
    send_byte(cmd);
    start_cond(1'b1);
    send_byte({DEV_ADDR, 1'b1});
    recv_byte(1'b0, data[7:0]);
    recv_byte(1'b1, data[15:8]);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [tb/coulomb_counter_compare_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ccc_map.svh"
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
// ----
// Bench top.
// ----
module coulomb_counter_compare_bench;
  logic        clock_in, reset_n_in;             // Clock and reset.
  logic        charge_unit_in, dischg_unit_in;   // Count strobes.
  logic        scl, host_oe, sda_wire;           // Bus lines.
  logic        sda_out, sda_oe_out;              // Device data drive.
  logic        host_alert_n_out, match_flag_out; // Device flags.
  logic [15:0] rd;                               // Last read word.
  int          miscompares, samples_checked;     // Run counters.

  // Data wire is pulled up unless a party pulls it low.
  assign sda_wire = !(host_oe || (sda_oe_out && !sda_out));

  coulomb_counter_compare u_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .charge_unit_in(charge_unit_in),
    .dischg_unit_in(dischg_unit_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .host_alert_n_out(host_alert_n_out), .match_flag_out(match_flag_out)
  );
  ccc_smbus_host u_host (.sda_in(sda_wire), .scl_out(scl), .sda_oe_out(host_oe));

  // Core clock of 8 ns.
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Sends n single-cycle strobes in one direction.
  task automatic pulse(input logic chg, input int n);
    repeat (n) begin
      @(negedge clock_in);
      charge_unit_in = chg;
      dischg_unit_in = !chg;
      @(negedge clock_in);
      charge_unit_in = 1'b0;
      dischg_unit_in = 1'b0;
    end
  endtask

  // Lets a command's effect land in the core.
  task automatic settle;
    repeat (12) @(negedge clock_in);
  endtask

  // Writes the configuration word.
  task automatic cfg(input logic sel, input logic clr, input logic en);
    logic [15:0] d;
    d = 16'h0000;
    d[`CCC_CFG_SELECT_BIT] = sel;
    d[`CCC_CFG_CLEAR_BIT] = clr;
    d[`CCC_CFG_ENABLE_BIT] = en;
    u_host.wr_word(`CCC_CMD_WR_CONFIG, d);
    settle();
  endtask

  // Reads the snapshot low half, then the high half.
  task automatic rd_tally(input logic [31:0] exp);
    u_host.rd_word(`CCC_CMD_RD_SNAP_LOW, rd);
    `CHK("snapshot low", exp[15:0], rd)
    u_host.rd_word(`CCC_CMD_RD_SNAP_HIGH, rd);
    `CHK("snapshot high", exp[31:16], rd)
  endtask

  // Waits a bounded time for the flag, then checks flag and alert.
  task automatic wait_flag(input logic exp);
    for (int i = 0; i < 40 && match_flag_out !== exp; i++) @(negedge clock_in);
    `CHK("match flag", exp, match_flag_out)
    `CHK("alert", !exp, host_alert_n_out)
  endtask

  // Prints the counts and the verdict.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end

  // Main sequence.
  initial begin
    reset_n_in = 1'b0;
    charge_unit_in = 1'b0;
    dischg_unit_in = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(negedge clock_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge clock_in);
    wait_flag(1'b0);
    u_host.rd_word(`CCC_CMD_RD_STATUS, rd);
    `CHK("status", {`CCC_STATUS_HIGH, 1'b0}, {rd[15:8], rd[`CCC_STS_MATCH_BIT]})
    pulse(1'b1, 300);
    pulse(1'b0, 7);
    cfg(1'b0, 1'b0, 1'b0);
    rd_tally(32'h0000_012c);
    cfg(1'b1, 1'b0, 1'b0);
    rd_tally(32'h0000_0007);
    cfg(1'b1, 1'b1, 1'b0);
    rd_tally(32'h0000_0000);
    cfg(1'b0, 1'b0, 1'b0);
    rd_tally(32'h0000_0000);
    u_host.wr_word(`CCC_CMD_WR_THR_LOW, 16'h0004);
    u_host.wr_word(`CCC_CMD_WR_THR_HIGH, 16'h0000);
    cfg(1'b0, 1'b0, 1'b1);
    pulse(1'b1, 3);
    pulse(1'b0, 5);
    settle();
    wait_flag(1'b0);
    pulse(1'b1, 1);
    wait_flag(1'b1);
    pulse(1'b1, 1);
    settle();
    wait_flag(1'b1);
    u_host.wr_word(`CCC_CMD_WR_THR_LOW, 16'h0006);
    settle();
    wait_flag(1'b0);
    u_host.wr_word(`CCC_CMD_WR_THR_HIGH, 16'h0001);
    pulse(1'b1, 1);
    settle();
    wait_flag(1'b0);
    u_host.wr_word(`CCC_CMD_WR_THR_LOW, 16'h0006);
    u_host.wr_word(`CCC_CMD_WR_THR_HIGH, 16'h0000);
    wait_flag(1'b1);
    `CHK("host nacks", 0, u_host.nack_count)
    end_sim();
  end
endmodule
`default_nettype wire
